// ==== design/meter_interrupt_mask_logic.sv ====
// Purpose: interrupt enable registers and flags of a polyphase meter
// Assumes: classic wishbone master, one-cycle event strobes
// Notes: register byte address is the register index times four
`timescale 1ns/1ps
`include "meter_irq_cfg.svh"

// Summary of operation
// - group A bits 11,12 enable phase B,C reactive sign change
// - group A bit 13 enables sign change of path two power sum
// - group A bit 14 enables pulse pin one fall, even disabled
// - group A bit 15 enables pulse pin two fall, even disabled
// - group A bit 16 enables pulse pin three fall, even disabled
// - group A bit 17 enables completion of the periodic DSP cycle
// - group A bit 18 enables sign change of path three power sum
// - group A bits 31 to 19 reserved, read zero, writes ignored
// - group B bit 0 enables no-load entry on total power
// - group B bit 1 enables no-load entry on fundamental power
// - group B bit 2 enables no-load entry on apparent power
// - group B bits 3 to 5 enable voltage crossing timeouts
// - group B bits 6 to 8 enable current crossing timeouts
// - group B bits 9 to 11 enable voltage zero crossings
// - group B bits 12,13 enable phase A,B current crossings
// - group B bit 14 enables phase C current zero crossing
// - reset complete always interrupts; its enable bit does nothing
module meter_interrupt_mask_logic (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // wishbone slave
   input wire meter_irq_pkg::wb_req_t wbReq,
   output meter_irq_pkg::wb_rsp_t wbRsp,
   // metering events
   input wire meter_irq_pkg::meter_events_t events,
   input wire logic [7:0] powerPulse,
   // energy pulse pins, active low
   output logic energyPulseOutOne_b,
   output logic energyPulseOutTwo_b,
   output logic energyPulseOutThree_b,
   // interrupt requests
   output logic irqGroupA,
   output logic irqGroupB,
   output logic irqOut
);
   import meter_irq_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic ack_reg;
   logic ack_next;
   logic [31:0] rdDat_reg;
   logic [31:0] rdDat_next;
   logic [`GRP_A_W-1:0] enableA_reg;
   logic [`GRP_A_W-1:0] enableA_next;
   logic [`GRP_B_W-1:0] enableB_reg;
   logic [`GRP_B_W-1:0] enableB_next;
   logic [`MEAS_MODE_W-1:0] measMode_reg;
   logic [`MEAS_MODE_W-1:0] measMode_next;
   logic [`PULSE_CFG_W-1:0] pulseCfg_reg;
   logic [`PULSE_CFG_W-1:0] pulseCfg_next;
   logic [`GRP_A_W-1:0] statusA;
   logic [`GRP_B_W-1:0] statusB;
   logic [`GRP_A_W-1:0] setA;
   logic [`GRP_B_W-1:0] setB;
   logic [`GRP_A_W-1:0] clrA;
   logic [`GRP_B_W-1:0] clrB;
   logic [2:0] pulsePin_b;
   logic [2:0] pulseFall;
   logic reqTaken;
   logic wrCommit;
   logic [31:0] wrMask;
   reg_sel_t regSel;

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   // address to register
   function automatic reg_sel_t decodeReg(input logic [17:0] adr);
      logic [15:0] idx;
      idx = adr[17:2];
      if (adr[1:0] != 2'h0) begin
         decodeReg = SEL_NONE;
      end else if (idx == `IDX_ENABLE_GROUP_A) begin
         decodeReg = SEL_ENABLE_A;
      end else if (idx == `IDX_ENABLE_GROUP_B) begin
         decodeReg = SEL_ENABLE_B;
      end else if (idx == `IDX_STATUS_GROUP_A) begin
         decodeReg = SEL_STATUS_A;
      end else if (idx == `IDX_STATUS_GROUP_B) begin
         decodeReg = SEL_STATUS_B;
      end else if (idx == `IDX_MEAS_MODE) begin
         decodeReg = SEL_MEAS_MODE;
      end else if (idx == `IDX_PULSE_CFG) begin
         decodeReg = SEL_PULSE_CFG;
      end else begin
         decodeReg = SEL_NONE;
      end
   endfunction

   // byte enables to bit mask
   function automatic logic [31:0] laneMask(input logic [3:0] sel);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            m[8*i +: 8] = 8'hFF;
         end
      end
      laneMask = m;
   endfunction

   // ----------------------------------------------------------------
   // wishbone slave
   // ----------------------------------------------------------------
   // request taken on first cycle, write lands on the ack edge
   always_comb begin
      regSel = decodeReg(wbReq.adr);
      reqTaken = wbReq.cyc & wbReq.stb & ~ack_reg;
      wrCommit = wbReq.cyc & wbReq.stb & wbReq.we & ack_reg;
      wrMask = laneMask(wbReq.sel);
      ack_next = reqTaken;
      rdDat_next = rdDat_reg;
      if (reqTaken) begin
         if (regSel == SEL_ENABLE_A) begin
            rdDat_next = {13'h0000, enableA_reg};
         end else if (regSel == SEL_ENABLE_B) begin
            rdDat_next = {16'h0000, enableB_reg};
         end else if (regSel == SEL_STATUS_A) begin
            rdDat_next = {13'h0000, statusA};
         end else if (regSel == SEL_STATUS_B) begin
            rdDat_next = {16'h0000, statusB};
         end else if (regSel == SEL_MEAS_MODE) begin
            rdDat_next = {30'h0000_0000, measMode_reg};
         end else if (regSel == SEL_PULSE_CFG) begin
            rdDat_next = {20'h00000, pulseCfg_reg};
         end else begin
            rdDat_next = 32'h0000_0000;
         end
      end
   end

   // bus answer registers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_reg <= 1'b0;
         rdDat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= ack_next;
         rdDat_reg <= rdDat_next;
      end
   end

   assign wbRsp = '{dat: rdDat_reg, ack: ack_reg};

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   // byte-lane merge of writes into the control registers
   always_comb begin
      enableA_next = enableA_reg;
      enableB_next = enableB_reg;
      measMode_next = measMode_reg;
      pulseCfg_next = pulseCfg_reg;
      if (wrCommit && regSel == SEL_ENABLE_A) begin
         enableA_next = (enableA_reg & ~wrMask[`GRP_A_W-1:0])
            | (wbReq.dat[`GRP_A_W-1:0] & wrMask[`GRP_A_W-1:0]);
      end
      if (wrCommit && regSel == SEL_ENABLE_B) begin
         enableB_next = (enableB_reg & ~wrMask[`GRP_B_W-1:0])
            | (wbReq.dat[`GRP_B_W-1:0] & wrMask[`GRP_B_W-1:0]);
      end
      if (wrCommit && regSel == SEL_MEAS_MODE) begin
         measMode_next = (measMode_reg & ~wrMask[`MEAS_MODE_W-1:0])
            | (wbReq.dat[`MEAS_MODE_W-1:0] & wrMask[`MEAS_MODE_W-1:0]);
      end
      if (wrCommit && regSel == SEL_PULSE_CFG) begin
         pulseCfg_next = (pulseCfg_reg & ~wrMask[`PULSE_CFG_W-1:0])
            | (wbReq.dat[`PULSE_CFG_W-1:0] & wrMask[`PULSE_CFG_W-1:0]);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         enableA_reg <= `ENABLE_A_RST;
         enableB_reg <= `ENABLE_B_RST;
         measMode_reg <= `MEAS_MODE_RST;
         pulseCfg_reg <= `PULSE_CFG_RST;
      end else begin
         enableA_reg <= enableA_next;
         enableB_reg <= enableB_next;
         measMode_reg <= measMode_next;
         pulseCfg_reg <= pulseCfg_next;
      end
   end

   // write-one-to-clear strobes for the flags
   always_comb begin
      clrA = '0;
      clrB = '0;
      if (wrCommit && regSel == SEL_STATUS_A) begin
         clrA = wbReq.dat[`GRP_A_W-1:0] & wrMask[`GRP_A_W-1:0];
      end
      if (wrCommit && regSel == SEL_STATUS_B) begin
         clrB = wbReq.dat[`GRP_B_W-1:0] & wrMask[`GRP_B_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // energy pulse outputs
   // ----------------------------------------------------------------
   // pin fall events kept
   for (genvar g = 0; g < 3; g++) begin : gPulse
      pulse_output_path uPath (
         .sys_clk(sys_clk),
         .rst_b(rst_b),
         .powerPulse(powerPulse),
         .powerSelect(pulseCfg_reg[`POS_PULSE_SELECT_BASE + 3*g +: 3]),
         .pinDisable(pulseCfg_reg[`POS_PULSE_DISABLE_BASE + g]),
         .pulseOut_b(pulsePin_b[g]),
         .fallEvent(pulseFall[g])
      );
   end

   assign energyPulseOutOne_b = pulsePin_b[0];
   assign energyPulseOutTwo_b = pulsePin_b[1];
   assign energyPulseOutThree_b = pulsePin_b[2];

   // ----------------------------------------------------------------
   // event routing to flags
   // ----------------------------------------------------------------
   // group A flag sources
   always_comb begin
      setA[10:0] = events.lowerGroupA;
      setA[12:11] = measMode_reg[`POS_REACTIVE_SIGN_SOURCE_SELECT]
         ? events.reactSignFund : events.reactSignTotal;
      setA[13] = events.sumSignTwo;
      setA[16:14] = pulseFall;
      setA[17] = events.dspCycleDone;
      setA[18] = events.sumSignThree;
   end

   // group B flag sources
   always_comb begin
      setB[0] = events.noloadTotal;
      setB[1] = events.noloadFund;
      setB[2] = events.noloadApparent;
      setB[5:3] = events.voltTimeout;
      setB[8:6] = events.currTimeout;
      setB[11:9] = events.voltCross;
      setB[13:12] = events.currCross[1:0];
      setB[14] = events.currCross[2];
      // reset complete flag comes up set from reset
      setB[15] = 1'b0;
   end

   // ----------------------------------------------------------------
   // flags and interrupt requests
   // ----------------------------------------------------------------
   irq_status_bank #(
      .W(`GRP_A_W),
      .RST_VAL(`STATUS_A_RST)
   ) uBankA (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .setBits(setA),
      .clrBits(clrA),
      .enableBits(enableA_reg),
      .forceBits('0),
      .statusOut(statusA),
      .irqOut(irqGroupA)
   );

   irq_status_bank #(
      .W(`GRP_B_W),
      .RST_VAL(`STATUS_B_RST)
   ) uBankB (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .setBits(setB),
      .clrBits(clrB),
      .enableBits({1'b0, enableB_reg[`GRP_B_W-2:0]}),
      .forceBits({1'b1, {(`GRP_B_W-1){1'b0}}}),
      .statusOut(statusB),
      .irqOut(irqGroupB)
   );

   assign irqOut = irqGroupA | irqGroupB;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   // answer exactly one cycle after the request is taken
   bus_ack_timing_a : assert property (
      (wbReq.cyc && wbReq.stb && !ack_reg) |=> ack_reg ##1 !ack_reg)
      else $error("ack not one cycle after request");

   reserved_read_zero_a : assert property (
      (ack_reg && !wbReq.we
         && decodeReg(wbReq.adr) == SEL_ENABLE_A)
      |-> (wbRsp.dat[31:19] == 13'h0000))
      else $error("reserved enable bits not zero");

   enables_reset_clear_a : assert property (
      !$past(rst_b) |-> (enableA_reg == '0 && enableB_reg == '0))
      else $error("enables not cleared after reset");

   group_a_request_a : assert property (
      (|(setA & enableA_next)) |=> irqGroupA)
      else $error("group A request wrong");

   reset_done_unmasked_a : assert property (
      statusB[`POS_RESET_COMPLETE_EVENT] |-> irqGroupB)
      else $error("reset complete not requesting");

   reactive_source_sel_a : assert property (
      (measMode_reg[`POS_REACTIVE_SIGN_SOURCE_SELECT]
         && events.reactSignFund[0])
      |=> statusA[11])
      else $error("fundamental reactive sign missed");

   pulse_fall_flag_a : assert property (
      (powerPulse[pulseCfg_reg[2:0]] && !gPulse[0].uPath.pulse_reg
         && $stable(pulseCfg_reg))
      |=> ##1 statusA[`POS_PULSE_ONE_EN])
      else $error("pulse one fall not flagged");

   dsp_done_irq_a : assert property (
      (events.dspCycleDone && enableA_next[`POS_DSP_CYCLE_DONE_EN])
      |=> irqGroupA && irqOut)
      else $error("dsp done not requesting");

   volt_timeout_flag_a : assert property (
      events.voltTimeout[0]
      |=> statusB[`POS_VOLT_A_CROSSING_TIMEOUT_EN])
      else $error("voltage timeout not flagged");

   // unmapped reads answer zero
   unmapped_read_zero_a : assert property (
      (wbReq.cyc && wbReq.stb && !ack_reg && !wbReq.we
         && decodeReg(wbReq.adr) == SEL_NONE)
      |=> (ack_reg && wbRsp.dat == 32'h0000_0000))
      else $error("unmapped read not zero");
endmodule // meter_interrupt_mask_logic

// ==== design/meter_irq_cfg.svh ====
// Purpose: constants of the metering interrupt enable block
// Assumes: register indices times four give the byte address
// Notes: included by the package, the top design module and the bench
`ifndef METER_IRQ_CFG_SVH
`define METER_IRQ_CFG_SVH

// ----------------------------------------------------------------
// bus widths
// ----------------------------------------------------------------
`define WB_ADR_W 18
`define WB_DAT_W 32

// ----------------------------------------------------------------
// register indices (byte address is index times four)
// ----------------------------------------------------------------
`define IDX_ENABLE_GROUP_A 16'hE50A
`define IDX_ENABLE_GROUP_B 16'hE50B
`define IDX_STATUS_GROUP_A 16'hE500
`define IDX_STATUS_GROUP_B 16'hE501
`define IDX_MEAS_MODE 16'hE700
`define IDX_PULSE_CFG 16'hE610

// ----------------------------------------------------------------
// register widths and reset values
// ----------------------------------------------------------------
`define GRP_A_W 19
`define GRP_B_W 16
`define MEAS_MODE_W 2
`define PULSE_CFG_W 12
`define ENABLE_A_RST 19'h00000
`define ENABLE_B_RST 16'h0000
`define STATUS_A_RST 19'h00000
`define STATUS_B_RST 16'h8000
`define MEAS_MODE_RST 2'h0
`define PULSE_CFG_RST 12'h000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define POS_REACTIVE_SIGN_SOURCE_SELECT 1
`define POS_PULSE_SELECT_BASE 0
`define POS_PULSE_DISABLE_BASE 9
`define POS_RESET_COMPLETE_EVENT 15
`define POS_PULSE_ONE_EN 14
`define POS_DSP_CYCLE_DONE_EN 17
`define POS_VOLT_A_CROSSING_TIMEOUT_EN 3

`endif

// ==== design/meter_irq_pkg.sv ====
// Purpose: shared types of the metering interrupt enable block
// Assumes: constants come from the cfg header
// Notes: bus request, bus answer and event bundles travel as structs
`include "meter_irq_cfg.svh"
package meter_irq_pkg;

   // ----------------------------------------------------------------
   // wishbone request and answer
   // ----------------------------------------------------------------
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [`WB_ADR_W-1:0] adr;
      logic [`WB_DAT_W-1:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic [`WB_DAT_W-1:0] dat;
      logic ack;
   } wb_rsp_t;

   // ----------------------------------------------------------------
   // one-cycle event strobes from the metering datapath
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [10:0] lowerGroupA;
      logic [1:0] reactSignTotal;
      logic [1:0] reactSignFund;
      logic sumSignTwo;
      logic sumSignThree;
      logic dspCycleDone;
      logic noloadTotal;
      logic noloadFund;
      logic noloadApparent;
      logic [2:0] voltTimeout;
      logic [2:0] currTimeout;
      logic [2:0] voltCross;
      logic [2:0] currCross;
   } meter_events_t;

   // ----------------------------------------------------------------
   // register decode result
   // ----------------------------------------------------------------
   typedef enum {
      SEL_NONE,
      SEL_ENABLE_A,
      SEL_ENABLE_B,
      SEL_STATUS_A,
      SEL_STATUS_B,
      SEL_MEAS_MODE,
      SEL_PULSE_CFG
   } reg_sel_t;

endpackage

// ==== design/irq_status_bank.sv ====
// Purpose: sticky event flags with write-one-to-clear and a mask
// Assumes: set and clear are one-cycle strobes
// Notes: a set in the clearing cycle wins; forced bits ignore the mask
`timescale 1ns/1ps
module irq_status_bank #(
   parameter int W = 16,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // flag control
   input wire logic [W-1:0] setBits,
   input wire logic [W-1:0] clrBits,
   input wire logic [W-1:0] enableBits,
   input wire logic [W-1:0] forceBits,
   // flag state
   output logic [W-1:0] statusOut,
   output logic irqOut
);
   logic [W-1:0] status_reg;
   logic [W-1:0] status_next;

   // set wins over clear
   always_comb begin
      status_next = (status_reg & ~clrBits) | setBits;
   end

   // flag storage
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         status_reg <= RST_VAL;
      end else begin
         status_reg <= status_next;
      end
   end

   assign statusOut = status_reg;
   assign irqOut = |(status_reg & (enableBits | forceBits));

   // a flag set is never lost to a clear
   set_wins_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (setBits != '0) |=> ((status_reg & $past(setBits)) == $past(setBits)))
      else $error("event flag lost");
endmodule // irq_status_bank

// ==== design/pulse_output_path.sv ====
// Purpose: one energy pulse pin with its falling-edge event
// Assumes: power pulses are active-high levels, one per power type
// Notes: the event still fires while the pin is held off
`timescale 1ns/1ps
module pulse_output_path (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // pulse source and config
   input wire logic [7:0] powerPulse,
   input wire logic [2:0] powerSelect,
   input wire logic pinDisable,
   // pin and event
   output logic pulseOut_b,
   output logic fallEvent
);
   logic pulse_reg;
   logic pulse_next;
   logic pin_reg;
   logic pin_next;
   logic fall_reg;
   logic fall_next;

   // pick the power type and find the pin's falling edge
   always_comb begin
      pulse_next = powerPulse[powerSelect];
      pin_next = pinDisable | ~pulse_next;
      fall_next = pulse_next & ~pulse_reg;
   end

   // pulse, pin and event registers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pulse_reg <= 1'b0;
         pin_reg <= 1'b1;
         fall_reg <= 1'b0;
      end else begin
         pulse_reg <= pulse_next;
         pin_reg <= pin_next;
         fall_reg <= fall_next;
      end
   end

   assign pulseOut_b = pin_reg;
   assign fallEvent = fall_reg;

   pin_disable_idle_a : assert property (@(posedge sys_clk)
      disable iff (!rst_b) pinDisable |=> pulseOut_b)
      else $error("pin driven while disabled");

   edge_despite_off_a : assert property (@(posedge sys_clk)
      disable iff (!rst_b)
      (powerPulse[powerSelect] && !pulse_reg && pinDisable)
      |=> fallEvent)
      else $error("pulse event missing while disabled");
endmodule // pulse_output_path

// ==== tb/test_meter_interrupt_mask_logic.sv ====
// Purpose: self-checking bench of the meter interrupt enable block
// Assumes: one-cycle event strobes, registered wishbone ack
// Notes: pulse pins are disabled until the mid-run reset, their fall events must still flag
`timescale 1ns/1ps
`include "meter_irq_cfg.svh"
module test_meter_interrupt_mask_logic;
   import meter_irq_pkg::*;
   logic sys_clk;
   logic rst_b;
   wb_req_t req;
   wb_rsp_t rsp;
   meter_events_t evs;
   logic [7:0] pulse;
   logic pinOne_b, pinTwo_b, pinThree_b, irqA, irqB, irqAny;
   int mismatches = 0;
   int cmpCount = 0;
   int cycles = 0;
   int b;
   logic [31:0] q;
   meter_events_t e;

   meter_interrupt_mask_logic dut (.sys_clk(sys_clk), .rst_b(rst_b),
      .wbReq(req), .wbRsp(rsp), .events(evs), .powerPulse(pulse),
      .energyPulseOutOne_b(pinOne_b), .energyPulseOutTwo_b(pinTwo_b),
      .energyPulseOutThree_b(pinThree_b), .irqGroupA(irqA),
      .irqGroupB(irqB), .irqOut(irqAny));

   // ----------------------------------------------------------------
   // clock, timeout and shared tasks
   // ----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // cut a hang short
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         stop_test();
      end
   end

   task chk(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task stop_test();
      $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
      if (mismatches == 0 && cmpCount > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // classic single wishbone cycle, waits for ack
   task wb(input logic w, input logic [15:0] idx, input logic [31:0] d,
           output logic [31:0] rd);
      @(posedge sys_clk);
      req <= {1'b1, 1'b1, w, 4'hF, idx, 2'b00, d};
      @(posedge sys_clk);
      while (rsp.ack !== 1'b1) @(posedge sys_clk);
      rd = rsp.dat;
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
      @(posedge sys_clk);
   endtask

   // one event strobe plus an optional power pulse
   task fire(input meter_events_t ev, input logic [7:0] p,
             input logic [2:0] pins);
      @(posedge sys_clk);
      evs <= ev;
      pulse <= p;
      @(posedge sys_clk);
      evs <= '0;
      repeat (3) @(posedge sys_clk);
      pulse <= 8'h00;
      chk("pins", {29'h0, pinOne_b, pinTwo_b, pinThree_b}, {29'h0, pins});
   endtask

   function automatic meter_events_t ev_for(input logic g, input int n);
      meter_events_t v;
      v = '0;
      if (g) begin
         if (n == 0) v.noloadTotal = 1'b1;
         else if (n == 1) v.noloadFund = 1'b1;
         else if (n == 2) v.noloadApparent = 1'b1;
         else if (n < 6) v.voltTimeout[n-3] = 1'b1;
         else if (n < 9) v.currTimeout[n-6] = 1'b1;
         else if (n < 12) v.voltCross[n-9] = 1'b1;
         else v.currCross[n-12] = 1'b1;
      end else begin
         if (n < 13) v.reactSignTotal[n-11] = 1'b1;
         else if (n == 13) v.sumSignTwo = 1'b1;
         else if (n == 17) v.dspCycleDone = 1'b1;
         else if (n == 18) v.sumSignThree = 1'b1;
      end
      return v;
   endfunction

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // flag sets, masked stays quiet, enabled requests, clear releases
   task test_bit(input logic g, input int n);
      logic [15:0] en;
      logic [15:0] st;
      logic [7:0] p;
      en = g ? `IDX_ENABLE_GROUP_B : `IDX_ENABLE_GROUP_A;
      st = g ? `IDX_STATUS_GROUP_B : `IDX_STATUS_GROUP_A;
      p = (!g && n > 13 && n < 17) ? 8'(1 << (n - 13)) : 8'h00;
      fire(ev_for(g, n), p, 3'h7);
      wb(1'b0, st, 32'h0, q);
      chk("flag", q, 32'h1 << n);
      chk("masked", {31'h0, g ? irqB : irqA}, 32'h0);
      wb(1'b1, en, 32'h1 << n, q);
      chk("irq on", {29'h0, irqA, irqB, irqAny}, g ? 32'h3 : 32'h5);
      wb(1'b1, st, 32'h1 << n, q);
      chk("irq off", {29'h0, irqA, irqB, irqAny}, 32'h0);
      wb(1'b1, en, 32'h0, q);
   endtask

   // reset values, reserved bits and the unmaskable reset flag
   task test_reset();
      wb(1'b0, `IDX_ENABLE_GROUP_A, 32'h0, q);
      chk("enable a", q, 32'h0);
      wb(1'b0, `IDX_ENABLE_GROUP_B, 32'h0, q);
      chk("enable b", q, 32'h0);
      chk("irq rst", {29'h0, irqA, irqB, irqAny}, 32'h3);
      wb(1'b0, `IDX_STATUS_GROUP_B, 32'h0, q);
      chk("status b", q, 32'h8000);
      wb(1'b1, `IDX_STATUS_GROUP_B, 32'h8000, q);
      chk("irq clr", {29'h0, irqA, irqB, irqAny}, 32'h0);
      wb(1'b1, `IDX_ENABLE_GROUP_B, 32'h8000, q);
      wb(1'b0, `IDX_ENABLE_GROUP_B, 32'h0, q);
      chk("enable b15", q, 32'h8000);
      chk("b15 no effect", {29'h0, irqA, irqB, irqAny}, 32'h0);
      wb(1'b1, `IDX_ENABLE_GROUP_B, 32'h0, q);
      wb(1'b1, `IDX_ENABLE_GROUP_A, 32'hFFFFFFFF, q);
      wb(1'b0, `IDX_ENABLE_GROUP_A, 32'h0, q);
      chk("reserved", q, 32'h0007FFFF);
      wb(1'b1, `IDX_ENABLE_GROUP_A, 32'h0, q);
      wb(1'b1, 16'h0001, 32'hFFFFFFFF, q);
      wb(1'b0, 16'h0001, 32'h0, q);
      chk("unmapped", q, 32'h0);
   endtask

   // source select picks fundamental over total reactive sign
   task test_source();
      wb(1'b1, `IDX_MEAS_MODE, 32'h2, q);
      fire(ev_for(1'b0, 11), 8'h00, 3'h7);
      wb(1'b0, `IDX_STATUS_GROUP_A, 32'h0, q);
      chk("total ignored", q, 32'h0);
      e = '0;
      e.reactSignFund[1] = 1'b1;
      fire(e, 8'h00, 3'h7);
      wb(1'b0, `IDX_STATUS_GROUP_A, 32'h0, q);
      chk("fund taken", q, 32'h1000);
      wb(1'b1, `IDX_STATUS_GROUP_A, 32'h1000, q);
      wb(1'b1, `IDX_MEAS_MODE, 32'h0, q);
   endtask

   // event in the clearing cycle keeps its flag; enabled flag requests
   task test_collide();
      e = '0;
      e.dspCycleDone = 1'b1;
      wb(1'b1, `IDX_ENABLE_GROUP_A, 32'h00020000, q);
      fire(e, 8'h00, 3'h7);
      chk("irq dsp", {29'h0, irqA, irqB, irqAny}, 32'h5);
      fork
         wb(1'b1, `IDX_STATUS_GROUP_A, 32'h00020000, q);
         begin
            repeat (2) @(posedge sys_clk);
            evs <= e;
            @(posedge sys_clk);
            evs <= '0;
         end
      join
      wb(1'b0, `IDX_STATUS_GROUP_A, 32'h0, q);
      chk("set wins", q, 32'h00020000);
      wb(1'b1, `IDX_STATUS_GROUP_A, 32'h00020000, q);
      wb(1'b1, `IDX_ENABLE_GROUP_A, 32'h0, q);
      chk("irq dsp off", {29'h0, irqA, irqB, irqAny}, 32'h0);
   endtask

   // mid-run reset clears enables; enabled pins then fall and flag
   task test_rerun();
      wb(1'b1, `IDX_ENABLE_GROUP_A, 32'h0007FFFF, q);
      wb(1'b1, `IDX_ENABLE_GROUP_B, 32'h0000FFFF, q);
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      wb(1'b0, `IDX_ENABLE_GROUP_A, 32'h0, q);
      chk("enable a rst", q, 32'h0);
      wb(1'b0, `IDX_ENABLE_GROUP_B, 32'h0, q);
      chk("enable b rst", q, 32'h0);
      chk("irq rerun", {29'h0, irqA, irqB, irqAny}, 32'h3);
      fire('0, 8'h01, 3'h0);
      wb(1'b0, `IDX_STATUS_GROUP_A, 32'h0, q);
      chk("pin flags", q, 32'h0001C000);
      wb(1'b1, `IDX_STATUS_GROUP_A, 32'h0001C000, q);
      wb(1'b1, `IDX_STATUS_GROUP_B, 32'h8000, q);
      chk("irq end", {29'h0, irqA, irqB, irqAny}, 32'h0);
   endtask

   // main sequence
   initial begin
      rst_b = 1'b0;
      req = '0;
      evs = '0;
      pulse = 8'h00;
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      test_reset();
      // select codes 1,2,3 for the pins, all three pins disabled
      wb(1'b1, `IDX_PULSE_CFG, 32'h00000ED1, q);
      for (b = 0; b < 3; b++) test_bit(1'b1, b);
      for (b = 3; b < 6; b++) test_bit(1'b1, b);
      for (b = 6; b < 9; b++) test_bit(1'b1, b);
      for (b = 9; b < 12; b++) test_bit(1'b1, b);
      for (b = 12; b < 14; b++) test_bit(1'b1, b);
      test_bit(1'b1, 14);
      for (b = 11; b < 13; b++) test_bit(1'b0, b);
      test_bit(1'b0, 13);
      test_bit(1'b0, 14);
      test_bit(1'b0, 15);
      test_bit(1'b0, 16);
      test_bit(1'b0, 17);
      test_bit(1'b0, 18);
      test_source();
      test_collide();
      test_rerun();
      stop_test();
   end
endmodule // test_meter_interrupt_mask_logic
